// ### rtl/dfw_pkg.sv
// shared constants, tables and types of the drive fault and warning manager
// assumes a single 10 MHz clock and an axi4-lite master on the register side
package dfw_pkg;
  // ==========================================================================
  // timing
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned FAULT_HOLD_S  = 20;                          // reset lock-out
  localparam int unsigned HOLD_CYCLES   = FAULT_HOLD_S * CLK_HZ;
  localparam int unsigned LAMP_STEP_MS  = 200;                         // one cadence step
  localparam int unsigned STEP_CYCLES   = LAMP_STEP_MS * (CLK_HZ / 1000);

  // ==========================================================================
  // register byte offsets
  localparam logic [7:0] OFS_LIVE_WARN    = 8'h00;
  localparam logic [7:0] OFS_LATCH_WARN   = 8'h04;
  localparam logic [7:0] OFS_LIVE_FAULT   = 8'h08;
  localparam logic [7:0] OFS_LATCH_FAULT  = 8'h0c;
  localparam logic [7:0] OFS_SUMMARY      = 8'h10;
  localparam logic [7:0] OFS_MASK_RESTORE = 8'h14;
  localparam logic [7:0] OFS_MASK_ENABLE  = 8'h18;
  localparam logic [7:0] OFS_MASK_SAFE    = 8'h1c;
  localparam logic [7:0] OFS_SAFE_CMD     = 8'h20;
  localparam logic [7:0] OFS_REACT_SEL    = 8'h24;
  localparam logic [7:0] OFS_CONTROL      = 8'h28;
  localparam logic [7:0] OFS_STATUS       = 8'h2c;

  // ==========================================================================
  // per-bit error classes
  localparam logic [31:0] FATAL_CLASS    = 32'h1080_4411;  // bits 0,4,10,14,23,28
  localparam logic [31:0] CAN_DISABLE    = 32'h0201_9188;  // faults that may be masked off
  localparam logic [31:0] CAN_SAFE_MOVE  = 32'h0000_0180;
  localparam logic [31:0] CAN_RESTORE    = 32'h0000_0008;
  localparam logic [31:0] HOLD_FAULTS    = 32'h0000_0410;  // short circuit, over-current
  localparam logic [31:0] CLASS_CURRENT  = 32'h0003_0410;
  localparam logic [31:0] CLASS_VOLTAGE  = 32'h0200_0009;
  localparam logic [31:0] CLASS_TEMP     = 32'h0800_0002;
  localparam logic [31:0] CLASS_COMM     = 32'h0000_0180;

  // summary byte bits and field positions
  localparam int SUM_GENERIC = 0;
  localparam int SUM_CURRENT = 1;
  localparam int SUM_VOLTAGE = 2;
  localparam int SUM_TEMP    = 3;
  localparam int SUM_COMM    = 4;
  localparam int SUM_MANUF   = 7;
  localparam int CW_RESET_BIT = 7;
  localparam logic [3:0] CW_ENABLE_OP = 4'hf;

  // ==========================================================================
  // lamp patterns and display order table (index = display order)
  localparam logic [2:0] PAT_OFF = 3'h0;
  localparam logic [2:0] PAT_ON  = 3'h1;
  localparam logic [2:0] PAT_BLK = 3'h2;
  localparam logic [2:0] PAT_FL1 = 3'h3;
  localparam logic [2:0] PAT_FL2 = 3'h4;
  localparam logic [2:0] PAT_FL3 = 3'h5;
  localparam int N_ORDER = 25;
  localparam logic [4:0] ORDER_BIT [N_ORDER] = '{5'd0, 5'd4, 5'd10, 5'd1, 5'd3, 5'd25, 5'd14,
    5'd23, 5'd13, 5'd6, 5'd24, 5'd8, 5'd7, 5'd12, 5'd20, 5'd16, 5'd17, 5'd5, 5'd21, 5'd26,
    5'd27, 5'd15, 5'd22, 5'd28, 5'd31};
  localparam logic [2:0] ORDER_A [N_ORDER] = '{PAT_ON, PAT_ON, PAT_ON, PAT_ON, PAT_ON, PAT_ON,
    PAT_BLK, PAT_BLK, PAT_BLK, PAT_BLK, PAT_BLK, PAT_FL1, PAT_FL1, PAT_FL1, PAT_FL1, PAT_FL1,
    PAT_FL1, PAT_FL2, PAT_FL2, PAT_FL2, PAT_BLK, PAT_FL2, PAT_BLK, PAT_FL3, PAT_FL3};
  localparam logic [2:0] ORDER_B [N_ORDER] = '{PAT_BLK, PAT_ON, PAT_ON, PAT_FL1, PAT_FL2,
    PAT_FL3, PAT_ON, PAT_BLK, PAT_FL1, PAT_FL2, PAT_FL3, PAT_ON, PAT_BLK, PAT_FL1, PAT_FL2,
    PAT_FL3, PAT_FL3, PAT_BLK, PAT_FL1, PAT_FL2, PAT_FL3, PAT_ON, PAT_ON, PAT_FL1, PAT_ON};

  localparam logic [1:0] COL_GREEN  = 2'h0;
  localparam logic [1:0] COL_ORANGE = 2'h1;
  localparam logic [1:0] COL_RED    = 2'h2;
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // types
  typedef enum logic [1:0] {DRV_SW_ON_DIS, DRV_OP_EN, DRV_FLT_REACT, DRV_FAULT} dfw_drive_t;
  typedef enum logic [1:0] {RX_NONE, RX_IMMEDIATE, RX_RAMP, RX_SAFE} dfw_react_t;

  typedef struct packed {
    logic       lamp_a;
    logic       lamp_b;
    logic [1:0] colour;
  } dfw_lamp_t;

  typedef struct packed {
    logic motor_disable;
    logic ramp_stop_req;
    logic safe_move_req;
  } dfw_motor_t;

  typedef struct packed {
    dfw_drive_t  drv;
    dfw_react_t  react;
    logic [31:0] live_warn;
    logic [31:0] latch_warn;
    logic [31:0] live_fault;
    logic [31:0] latch_fault;
    logic [7:0]  summary;
    logic [31:0] m_restore;
    logic [31:0] m_enable;
    logic [31:0] m_safe;
    logic        safe_cmd;
    logic [2:0]  react_sel;
    logic [15:0] ctrl;
    logic        cw_reset_prev;
    logic [31:0] hold_cnt;
    logic [31:0] presc;
    logic [3:0]  step;
    dfw_lamp_t   lamp;
    logic        aw_held;
    logic        w_held;
    logic [7:0]  awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } dfw_state_t;
endpackage

// ### rtl/dfw_manager.sv
// fault and warning supervisor of a servo drive with an axi4-lite register port
// assumes error causes arrive as levels from logic on aclk, and that the motion
// logic reports the end of a ramp stop or a safe-position move with a pulse
//
// Design decisions made here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module dfw_manager
  import dfw_pkg::*;
#(
  parameter int unsigned HOLD_CYC = HOLD_CYCLES,
  parameter int unsigned STEP_CYC = STEP_CYCLES
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [31:0] warning_cause,
  input  wire logic [31:0] fault_cause,
  input  wire logic        ramp_done,
  input  wire logic        safe_move_done,
  output dfw_motor_t       motor,
  output dfw_lamp_t        lamps,
  output dfw_drive_t       drive_state,
  output logic [2:0]       fault_reaction_select,
  output logic [7:0]       summary_error_byte
);

  // ==========================================================================
  // helpers
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // flash n: lit on even steps below 2n, dark for the rest of the 16-step frame
  function automatic logic pat_level(input logic [2:0] p, input logic [3:0] s);
    logic lv;
    lv = 1'b0;
    case (p)
      PAT_ON:  lv = 1'b1;
      PAT_BLK: lv = s[0];
      PAT_FL1: lv = !s[0] && (s[3:1] < 3'd1);
      PAT_FL2: lv = !s[0] && (s[3:1] < 3'd2);
      PAT_FL3: lv = !s[0] && (s[3:1] < 3'd3);
      default: lv = 1'b0;
    endcase
    return lv;
  endfunction

  // higher priority reaction has the lower code
  function automatic dfw_react_t stronger(input dfw_react_t a, input dfw_react_t b);
    if (a == RX_NONE) begin
      return b;
    end
    if (b == RX_NONE) begin
      return a;
    end
    return (a < b) ? a : b;
  endfunction

  dfw_state_t s_r;
  dfw_state_t s_nxt;

  // ==========================================================================
  // next-state logic
  always_comb begin
    logic [31:0] warn_now;
    logic [31:0] fault_now;
    logic [31:0] new_fault;
    logic [31:0] all_err;
    logic [31:0] show;
    logic [31:0] rd;
    logic        wr_go;
    logic        rd_ok;
    logic        wr_ok;
    logic        clr_warn;
    logic        cw_edge;
    logic        do_reset;
    logic        clr_latched;
    logic        step_tick;
    logic        safe_ok;
    int          pick;
    dfw_react_t  want;
    warn_now    = '0;
    fault_now   = '0;
    new_fault   = '0;
    all_err     = '0;
    show        = '0;
    rd          = '0;
    wr_go       = 1'b0;
    rd_ok       = 1'b0;
    wr_ok       = 1'b0;
    clr_warn    = 1'b0;
    cw_edge     = 1'b0;
    do_reset    = 1'b0;
    clr_latched = 1'b0;
    step_tick   = 1'b0;
    safe_ok     = 1'b0;
    pick        = -1;
    want        = RX_NONE;
    s_nxt       = s_r;

    // ---- axi write: address and data taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      s_nxt.aw_held = 1'b1;
      s_nxt.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_nxt.w_held = 1'b1;
      s_nxt.wdata  = s_axi_wdata;
      s_nxt.wstrb  = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    wr_go = s_r.aw_held && s_r.w_held && !s_r.bvalid;
    if (wr_go) begin
      wr_ok = 1'b1;
      unique case (s_r.awaddr[7:2])
        OFS_LATCH_WARN[7:2]:   clr_warn = 1'b1;
        OFS_MASK_RESTORE[7:2]: s_nxt.m_restore = merge(s_r.m_restore, s_r.wdata, s_r.wstrb);
        OFS_MASK_ENABLE[7:2]:  s_nxt.m_enable = merge(s_r.m_enable, s_r.wdata, s_r.wstrb);
        OFS_MASK_SAFE[7:2]:    s_nxt.m_safe = merge(s_r.m_safe, s_r.wdata, s_r.wstrb);
        OFS_SAFE_CMD[7:2]:     s_nxt.safe_cmd = s_r.wstrb[0] ? s_r.wdata[0] : s_r.safe_cmd;
        OFS_REACT_SEL[7:2]:    s_nxt.react_sel = s_r.wstrb[0] ? s_r.wdata[2:0] : s_r.react_sel;
        OFS_CONTROL[7:2]:      s_nxt.ctrl = 16'(merge({16'h0000, s_r.ctrl}, s_r.wdata,
                                                      s_r.wstrb));
        OFS_LIVE_WARN[7:2], OFS_LIVE_FAULT[7:2], OFS_LATCH_FAULT[7:2],
        OFS_SUMMARY[7:2], OFS_STATUS[7:2]: wr_ok = 1'b1;                    // read-only, ignored
        default:               wr_ok = 1'b0;
      endcase
      s_nxt.aw_held = 1'b0;
      s_nxt.w_held  = 1'b0;
      s_nxt.bvalid  = 1'b1;
      s_nxt.bresp   = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end

    // ---- axi read: one cycle after the address is taken
    if (s_axi_rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rd_ok = 1'b1;
      unique case (s_axi_araddr[7:2])
        OFS_LIVE_WARN[7:2]:    rd = s_r.live_warn;
        OFS_LATCH_WARN[7:2]:   rd = s_r.latch_warn;
        OFS_LIVE_FAULT[7:2]:   rd = s_r.live_fault;
        OFS_LATCH_FAULT[7:2]:  rd = s_r.latch_fault;
        OFS_SUMMARY[7:2]:      rd = {24'h00_0000, s_r.summary};
        OFS_MASK_RESTORE[7:2]: rd = s_r.m_restore;
        OFS_MASK_ENABLE[7:2]:  rd = s_r.m_enable;
        OFS_MASK_SAFE[7:2]:    rd = s_r.m_safe;
        OFS_SAFE_CMD[7:2]:     rd = {31'h0000_0000, s_r.safe_cmd};
        OFS_REACT_SEL[7:2]:    rd = {29'h0000_0000, s_r.react_sel};
        OFS_CONTROL[7:2]:      rd = {16'h0000, s_r.ctrl};
        OFS_STATUS[7:2]:       rd = {22'h00_0000, s_r.hold_cnt != 32'h0, s_r.lamp, 1'b0,
                                     s_r.react, s_r.drv};
        default:               rd_ok = 1'b0;
      endcase
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata  = rd;
      s_nxt.rresp  = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end

    // ---- live and latched flags; a set in the clearing cycle wins
    warn_now  = warning_cause;
    fault_now = fault_cause & (s_r.m_enable | ~CAN_DISABLE);
    new_fault = fault_now & ~s_r.live_fault;
    s_nxt.live_warn  = warn_now;
    s_nxt.live_fault = fault_now;
    s_nxt.latch_warn = (clr_warn ? 32'h0 : s_r.latch_warn) | warn_now;

    // ---- summary byte follows the live causes only
    all_err = warn_now | fault_now;
    s_nxt.summary = '0;
    s_nxt.summary[SUM_GENERIC] = all_err != 32'h0;
    s_nxt.summary[SUM_CURRENT] = (all_err & CLASS_CURRENT) != 32'h0;
    s_nxt.summary[SUM_VOLTAGE] = (all_err & CLASS_VOLTAGE) != 32'h0;
    s_nxt.summary[SUM_TEMP]    = (all_err & CLASS_TEMP) != 32'h0;
    s_nxt.summary[SUM_COMM]    = (all_err & CLASS_COMM) != 32'h0;
    s_nxt.summary[SUM_MANUF]   = (all_err & ~(CLASS_CURRENT | CLASS_VOLTAGE | CLASS_TEMP
                                 | CLASS_COMM)) != 32'h0;

    // ---- lock-out counter restarted by each short-circuit or over-current event
    if ((new_fault & HOLD_FAULTS) != 32'h0) begin
      s_nxt.hold_cnt = 32'(HOLD_CYC);
    end else if (s_r.hold_cnt != 32'h0) begin
      s_nxt.hold_cnt = s_r.hold_cnt - 32'h1;
    end

    // ---- reaction wanted by the newly raised faults: immediate first, then safe move, then react_sel
    safe_ok = (s_r.drv == DRV_OP_EN) && s_r.safe_cmd
              && ((new_fault & ~(s_r.m_safe & CAN_SAFE_MOVE)) == 32'h0);
    if ((new_fault & FATAL_CLASS) != 32'h0 || s_r.drv == DRV_SW_ON_DIS) begin
      want = RX_IMMEDIATE;
    end else if (safe_ok) begin
      want = RX_SAFE;
    end else if (s_r.react_sel == 3'h0) begin
      want = RX_IMMEDIATE;                                                  // option 0: no ramp
    end else begin
      want = RX_RAMP;
    end

    // ---- fault reset request: rising edge of control bit 7
    s_nxt.cw_reset_prev = s_r.ctrl[CW_RESET_BIT];
    cw_edge  = s_r.ctrl[CW_RESET_BIT] && !s_r.cw_reset_prev;
    do_reset = (s_r.drv == DRV_FAULT) && (s_r.hold_cnt == 32'h0)
               && (cw_edge || (s_r.latch_fault != 32'h0 && s_r.live_fault == 32'h0
               && (s_r.latch_fault & ~(s_r.m_restore & CAN_RESTORE)) == 32'h0));
    clr_latched = do_reset && (s_r.latch_fault != 32'h0);
    s_nxt.latch_fault = (clr_latched ? 32'h0 : s_r.latch_fault) | fault_now;
    if (clr_latched) begin
      s_nxt.latch_warn = warn_now;
    end

    // ---- drive state machine; warnings never move it
    unique case (s_r.drv)
      DRV_SW_ON_DIS: begin
        if (new_fault != 32'h0) begin
          s_nxt.drv   = DRV_FLT_REACT;
          s_nxt.react = want;
        end else if (s_r.ctrl[3:0] == CW_ENABLE_OP && fault_now == 32'h0) begin
          s_nxt.drv = DRV_OP_EN;
        end
      end
      DRV_OP_EN: begin
        if (new_fault != 32'h0) begin
          s_nxt.drv   = DRV_FLT_REACT;
          s_nxt.react = want;
        end else if (s_r.ctrl[3:0] != CW_ENABLE_OP) begin
          s_nxt.drv = DRV_SW_ON_DIS;
        end
      end
      DRV_FLT_REACT: begin
        if (new_fault != 32'h0) begin
          s_nxt.react = stronger(s_r.react, want);
        end
        if (s_nxt.react == RX_IMMEDIATE
            || (s_r.react == RX_RAMP && ramp_done && s_nxt.react == RX_RAMP)
            || (s_r.react == RX_SAFE && safe_move_done && s_nxt.react == RX_SAFE)) begin
          s_nxt.drv   = DRV_FAULT;
          s_nxt.react = RX_NONE;
        end
      end
      DRV_FAULT: begin
        if (do_reset && fault_now == 32'h0) begin
          s_nxt.drv = DRV_SW_ON_DIS;
        end
      end
    endcase

    // ---- cadence prescaler, free running
    step_tick = s_r.presc >= 32'(STEP_CYC - 1);
    s_nxt.presc = step_tick ? 32'h0 : s_r.presc + 32'h1;
    if (step_tick) begin
      s_nxt.step = s_r.step + 4'h1;
    end

    // ---- lamps: faults hide warnings; lowest order wins
    show = s_r.live_fault | s_r.latch_fault;
    if (show == 32'h0) begin
      show = s_r.live_warn;
    end
    for (int i = N_ORDER - 1; i >= 0; i--) begin
      if (show[ORDER_BIT[i]]) begin
        pick = i;
      end
    end
    if (pick < 0) begin
      s_nxt.lamp.lamp_a = 1'b1;
      s_nxt.lamp.lamp_b = 1'b1;
    end else begin
      s_nxt.lamp.lamp_a = pat_level(ORDER_A[pick], s_r.step);
      s_nxt.lamp.lamp_b = pat_level(ORDER_B[pick], s_r.step);
    end
    if ((s_r.live_fault | s_r.latch_fault) != 32'h0) begin
      s_nxt.lamp.colour = COL_RED;
    end else if (s_r.live_warn != 32'h0) begin
      s_nxt.lamp.colour = COL_ORANGE;
    end else begin
      s_nxt.lamp.colour = COL_GREEN;
    end
  end

  // ==========================================================================
  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r             <= '0;
      s_r.drv         <= DRV_SW_ON_DIS;
      s_r.react       <= RX_NONE;
      s_r.react_sel   <= 3'h2;
      s_r.lamp.lamp_a <= 1'b1;
      s_r.lamp.lamp_b <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================================
  // outputs
  assign s_axi_awready = !s_r.aw_held && !s_r.bvalid;
  assign s_axi_wready  = !s_r.w_held && !s_r.bvalid;
  assign s_axi_bvalid  = s_r.bvalid;
  assign s_axi_bresp   = s_r.bresp;
  assign s_axi_arready = !s_r.rvalid;
  assign s_axi_rvalid  = s_r.rvalid;
  assign s_axi_rdata   = s_r.rdata;
  assign s_axi_rresp   = s_r.rresp;

  // motor stays off outside operation enable, except while a ramp stop or a safe-position move runs
  assign motor.motor_disable = (s_r.drv != DRV_OP_EN) && !(s_r.drv == DRV_FLT_REACT
                               && s_r.react != RX_IMMEDIATE);
  assign motor.ramp_stop_req = (s_r.drv == DRV_FLT_REACT) && (s_r.react == RX_RAMP);
  assign motor.safe_move_req = (s_r.drv == DRV_FLT_REACT) && (s_r.react == RX_SAFE);
  assign lamps                 = s_r.lamp;
  assign drive_state           = s_r.drv;
  assign fault_reaction_select = s_r.react_sel;
  assign summary_error_byte    = s_r.summary;

endmodule
`default_nettype wire

// ### tb/dfw_monitor.sv
// port assertions for the fault manager
// assumes one clock domain and the bind at the foot
`timescale 1ns/1ps
`default_nettype none
// ====================
// checker
module dfw_monitor
  import dfw_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [31:0] fault_cause,
  input wire dfw_motor_t  motor,
  input wire dfw_lamp_t   lamps,
  input wire dfw_drive_t  drive_state,
  input wire logic [7:0]  summary_error_byte
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // fatal causes cannot be masked, so no enable check needed
  wire logic fatal = |(fault_cause & FATAL_CLASS);
  property p_red; drive_state == DRV_FAULT |-> lamps.colour == COL_RED; endproperty
  a_red: assert property (p_red) else $error("fault state not red");
  property p_react; $rose(drive_state == DRV_FLT_REACT) |-> ##[0:2] lamps.colour == COL_RED;
  endproperty
  a_react: assert property (p_react) else $error("reaction not red");
  property p_fatal; fatal |-> ##[1:3] (motor.motor_disable && !motor.ramp_stop_req); endproperty
  a_fatal: assert property (p_fatal) else $error("fatal not disabled");
  property p_sum; fatal |-> ##[1:3] summary_error_byte[0]; endproperty
  a_sum: assert property (p_sum) else $error("generic bit missing");
  property p_gen; |summary_error_byte[7:1] |-> summary_error_byte[0]; endproperty
  a_gen: assert property (p_gen) else $error("generic bit cleared early");
  property p_one; $onehot0(motor); endproperty
  a_one: assert property (p_one) else $error("two reactions");
  property p_warn;
    (drive_state != DRV_FLT_REACT && fault_cause == 32'h0)[*3] |=> drive_state != DRV_FLT_REACT;
  endproperty
  a_warn: assert property (p_warn) else $error("reaction without fault");
  property p_rst; $fell(drive_state == DRV_FAULT) |-> drive_state == DRV_SW_ON_DIS; endproperty
  a_rst: assert property (p_rst) else $error("bad exit from fault");
  c_ramp: cover property (motor.ramp_stop_req);
  c_safe: cover property (motor.safe_move_req);
  c_fault: cover property ($fell(drive_state == DRV_FAULT));
endmodule
bind dfw_manager dfw_monitor u_mon (.aclk, .aresetn, .fault_cause, .motor, .lamps,
  .drive_state, .summary_error_byte);
`default_nettype wire

// ### tb/dfw_motion_model.sv
// motion logic stand-in answering ramp and safe-move requests
// assumes requests stand as levels until answered
`timescale 1ns/1ps
`default_nettype none
// ====================
// motion model
module dfw_motion_model
  import dfw_pkg::*;
(
  input  wire logic       aclk,
  input  wire dfw_motor_t motor,
  input  wire logic [7:0] delay,
  output logic            ramp_done = 1'b0,
  output logic            safe_move_done = 1'b0
);
  logic [7:0] cnt_r = 8'h00;
  // slow or prompt answer, chosen by the bench through delay
  always_ff @(posedge aclk) begin
    cnt_r <= (motor.ramp_stop_req || motor.safe_move_req) ? cnt_r + 8'h01 : 8'h00;
    ramp_done <= motor.ramp_stop_req && cnt_r == delay;
    safe_move_done <= motor.safe_move_req && cnt_r == delay;
  end
endmodule
`default_nettype wire

// ### tb/drive_fault_warning_manager_bench.sv
// self-checking bench for the fault manager
// assumes the motion model and the port checker beside it
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fail_count++; \
  $display("[ERR] %0t got %0h exp %0h", $time, a, b); end end
// ====================
// bench
module drive_fault_warning_manager_bench;
  import dfw_pkg::*;
  logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, dly = 8'h02;
  logic [31:0] wdata = 32'h0, wcause = 32'h0, fcause = 32'h0, rdat, acc = 32'h0;
  logic [1:0]  rsp;
  wire logic   awready, wready, bvalid, arready, rvalid, rdone, sdone;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire dfw_motor_t motor;
  wire dfw_lamp_t lamps;
  wire dfw_drive_t dstate;
  wire logic [2:0] rsel;
  wire logic [7:0] sumb;
  int compares = 0, fail_count = 0;
  dfw_manager #(.HOLD_CYC(150), .STEP_CYC(4)) dut (.aclk, .aresetn, .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(1'b1), .warning_cause(wcause), .fault_cause(fcause), .ramp_done(rdone),
    .safe_move_done(sdone), .motor, .lamps, .drive_state(dstate),
    .fault_reaction_select(rsel), .summary_error_byte(sumb));
  dfw_motion_model u_mot (.aclk, .motor, .delay(dly), .ramp_done(rdone), .safe_move_done(sdone));
  initial begin
    forever #50 aclk = ~aclk;
  end
  task automatic end_sim();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic tmo(input int n);
    if (n >= 200) begin
      fail_count++;
      end_sim();
    end
  endtask
  // ready lines stay high, so each answer is taken at its first edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 200);
    rsp = bresp;
    tmo(n);
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 200);
    rdat = rdata;
    rsp = rresp;
    tmo(n);
  endtask
  task automatic wait_st(input dfw_drive_t s);
    int n;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (dstate !== s && n < 200);
    tmo(n);
  endtask
  function automatic dfw_motor_t react(input logic [31:0] f, input logic safe);
    return |(f & FATAL_CLASS) ? 3'b100 : (safe ? 3'b001 : 3'b010);
  endfunction
  // lowest display order among the set error bits
  function automatic int order_of(input logic [31:0] f);
    int o;
    o = 0;
    for (int i = N_ORDER - 1; i >= 0; i--) begin
      if (f[ORDER_BIT[i]]) o = i;
    end
    return o;
  endfunction
  // lit cycles in one 16-step frame of 4-cycle steps (step length set at the instance)
  function automatic int lit(input logic [2:0] p);
    return p == PAT_ON ? 64 : p == PAT_BLK ? 32 : p == PAT_FL1 ? 4 : p == PAT_FL2 ? 8
      : p == PAT_FL3 ? 12 : 0;
  endfunction
  // a whole frame is counted, so the phase of the prescaler does not matter
  task automatic lamp_run(input logic [31:0] f);
    logic [7:0] na, nb;
    na = 8'h00;
    nb = 8'h00;
    repeat (64) begin
      @(posedge aclk);
      na = na + 8'(lamps.lamp_a);
      nb = nb + 8'(lamps.lamp_b);
    end
    `CHK(na, 8'(lit(ORDER_A[order_of(f)])))
    `CHK(nb, 8'(lit(ORDER_B[order_of(f)])))
    `CHK(lamps.colour, COL_RED)
  endtask
  // one fault from operation enable through its reaction and reset
  task automatic fault_run(input logic [31:0] f, input logic safe, input logic hold);
    dly <= 8'($urandom_range(20, 1));
    wr(OFS_CONTROL, 32'hf);
    wait_st(DRV_OP_EN);
    fcause <= f;
    wait_st(DRV_FLT_REACT);
    `CHK(motor, react(f, safe))
    wait_st(DRV_FAULT);
    `CHK(sumb[0], 1'b1)
    lamp_run(f);
    wr(OFS_CONTROL, 32'h0);
    wr(OFS_CONTROL, 32'h80);
    repeat (3) @(posedge aclk);
    `CHK(dstate, DRV_FAULT)
    fcause <= 32'h0;
    rd(OFS_LATCH_FAULT);
    `CHK(rdat, f)
    wr(OFS_CONTROL, 32'h0);
    wr(OFS_CONTROL, 32'h80);
    repeat (3) @(posedge aclk);
    `CHK(dstate, hold ? DRV_FAULT : DRV_SW_ON_DIS)
    repeat (100) @(posedge aclk);
    wr(OFS_CONTROL, 32'h0);
    wr(OFS_CONTROL, 32'h80);
    wait_st(DRV_SW_ON_DIS);
    rd(OFS_LATCH_FAULT);
    `CHK(rdat, 32'h0)
    `CHK(sumb, 8'h00)
    $display("fault test %0h done", f);
  endtask
  // main sequence: reset, warnings, faults
  initial begin
    void'($urandom(32'h6ac3));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    `CHK(rsel, 3'h2)
    rd(8'h40);
    `CHK(rsp, RESP_SLVERR)
    for (int i = 0; i < 4; i++) begin
      wcause <= ($urandom & 32'h0e73_356b) | 32'h0002_0000;
      repeat (3) @(posedge aclk);
      acc = acc | wcause;
      rd(OFS_LIVE_WARN);
      `CHK(rdat, wcause)
      `CHK(lamps.colour, COL_ORANGE)
      `CHK(dstate, DRV_SW_ON_DIS)
    end
    wcause <= 32'h0;
    repeat (3) @(posedge aclk);
    rd(OFS_LIVE_WARN);
    `CHK(rdat, 32'h0)
    rd(OFS_LATCH_WARN);
    `CHK(rdat, acc)
    wr(OFS_LATCH_WARN, $urandom);
    `CHK(rsp, RESP_OKAY)
    rd(OFS_LATCH_WARN);
    `CHK(rdat, 32'h0)
    $display("warning test done");
    wr(OFS_MASK_ENABLE, 32'hffff_ffff);
    wr(OFS_MASK_SAFE, 32'h0000_0100);
    wr(OFS_SAFE_CMD, 32'h1);
    fault_run(32'h0000_1000, 1'b0, 1'b0);
    fault_run(32'h0000_0100, 1'b1, 1'b0);
    fault_run(32'h0000_0080, 1'b0, 1'b0);
    fault_run(32'h0000_0010, 1'b0, 1'b1);
    fault_run(32'h1000_0000, 1'b0, 1'b0);
    end_sim();
  end
endmodule
`default_nettype wire
